// ===== hw/mvm_pkg.sv
// Constants and types shared by the vector-magnitude change detector
package mvm_pkg;

  // Register bus widths
  localparam int MVM_ADDR_W = 8;
  localparam int MVM_REG_W = 8;

  // Sample and setting widths
  localparam int MVM_DATA_W = 16;
  localparam int MVM_THS_W = 15;
  localparam int MVM_CNT_W = 8;

  // Register addresses
  localparam logic [MVM_ADDR_W-1:0] MVM_SRC_ADDR = 8'h5E;
  localparam logic [MVM_ADDR_W-1:0] MVM_CFG_ADDR = 8'h69;

  // Reset values
  localparam logic [MVM_REG_W-1:0] MVM_CFG_RESET = 8'h00;
  localparam logic [MVM_REG_W-1:0] MVM_RDATA_IDLE = 8'h00;

  // Configuration field positions
  localparam int MVM_CFG_LATCH_BIT = 7;
  localparam int MVM_CFG_INITM_BIT = 6;
  localparam int MVM_CFG_UPDM_BIT = 5;
  localparam int MVM_CFG_EN_BIT = 4;
  localparam int MVM_CFG_WAKE_BIT = 3;
  localparam int MVM_CFG_INT_EN_BIT = 2;
  localparam int MVM_CFG_ROUTE_BIT = 1;

  // Event source field position
  localparam int MVM_SRC_VECM_BIT = 1;

  // Debounce states
  typedef enum logic [1:0] {
    MVM_DEB_IDLE = 2'h0,
    MVM_DEB_COUNT = 2'h1,
    MVM_DEB_FIRED = 2'h2
  } mvm_deb_state_t;

endpackage : mvm_pkg

// ===== hw/mvm_dist.sv
// Squared distance of a sample from the reference, compared to the threshold
module mvm_dist #(
  parameter int DATA_W = mvm_pkg::MVM_DATA_W,
  parameter int THS_W = mvm_pkg::MVM_THS_W
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic sample_valid_in,
  input wire logic [DATA_W-1:0] mag_x_in,
  input wire logic [DATA_W-1:0] mag_y_in,
  input wire logic [DATA_W-1:0] mag_z_in,
  input wire logic [DATA_W-1:0] ref_x_in,
  input wire logic [DATA_W-1:0] ref_y_in,
  input wire logic [DATA_W-1:0] ref_z_in,
  input wire logic [THS_W-1:0] threshold_in,
  output logic valid_out,
  output logic over_out,
  output logic [DATA_W-1:0] samp_x_out,
  output logic [DATA_W-1:0] samp_y_out,
  output logic [DATA_W-1:0] samp_z_out
);

  localparam int SQ_W = 2 * (DATA_W + 1);
  localparam int SUM_W = SQ_W + 2;

  function automatic logic [SQ_W-1:0] mvm_sq(input logic signed [DATA_W:0] d);
    logic signed [SQ_W-1:0] p;
    p = d * d;
    return $unsigned(p);
  endfunction : mvm_sq

  function automatic logic signed [DATA_W:0] mvm_diff(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
    return $signed({a[DATA_W-1], a}) - $signed({b[DATA_W-1], b});
  endfunction : mvm_diff

  logic [SUM_W-1:0] dist_sq;
  logic [SUM_W-1:0] ths_sq;
  logic valid_q;
  logic over_q;
  logic [DATA_W-1:0] sx_q;
  logic [DATA_W-1:0] sy_q;
  logic [DATA_W-1:0] sz_q;

  // Squares avoid a root: |d| > ths  <=>  d^2 > ths^2
  assign dist_sq = SUM_W'(mvm_sq(mvm_diff(mag_x_in, ref_x_in))) + SUM_W'(mvm_sq(mvm_diff(mag_y_in, ref_y_in)))
                 + SUM_W'(mvm_sq(mvm_diff(mag_z_in, ref_z_in)));
  assign ths_sq = SUM_W'(threshold_in) * SUM_W'(threshold_in);

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      valid_q <= 1'b0;
      over_q <= 1'b0;
      sx_q <= '0;
      sy_q <= '0;
      sz_q <= '0;
    end else begin
      valid_q <= sample_valid_in;
      if (sample_valid_in) begin
        over_q <= dist_sq > ths_sq; // see R14
        sx_q <= mag_x_in;
        sy_q <= mag_y_in;
        sz_q <= mag_z_in;
      end
    end
  end

  assign valid_out = valid_q;
  assign over_out = over_q;
  assign samp_x_out = sx_q;
  assign samp_y_out = sy_q;
  assign samp_z_out = sz_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  a_dist_latency: assert property (sample_valid_in |=> valid_out && samp_x_out == $past(mag_x_in)) // see R14
    else $error("distance result not one cycle after sample");

endmodule : mvm_dist

// ===== hw/mvm_debounce.sv
// Counts consecutive over-threshold samples and fires once past the limit
module mvm_debounce #(
  parameter int CNT_W = mvm_pkg::MVM_CNT_W
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic enable_in,
  input wire logic valid_in,
  input wire logic over_in,
  input wire logic [CNT_W-1:0] limit_in,
  output logic event_out,
  output logic active_out
);

  mvm_pkg::mvm_deb_state_t state_q;
  mvm_pkg::mvm_deb_state_t state_d;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic [CNT_W:0] count_next;
  logic past_limit;

  assign count_next = {1'b0, count_q} + (CNT_W + 1)'(1);
  assign past_limit = count_next > {1'b0, limit_in}; // see R14

  always_comb begin
    state_d = state_q;
    count_d = count_q;
    event_out = 1'b0;
    if (!enable_in) begin
      state_d = mvm_pkg::MVM_DEB_IDLE;
      count_d = '0;
    end else if (valid_in && !over_in) begin
      state_d = mvm_pkg::MVM_DEB_IDLE;
      count_d = '0;
    end else if (valid_in) begin
      case (state_q)
        mvm_pkg::MVM_DEB_IDLE,
        mvm_pkg::MVM_DEB_COUNT: begin
          if (past_limit) begin
            state_d = mvm_pkg::MVM_DEB_FIRED;
            event_out = 1'b1; // see R14
          end else begin
            state_d = mvm_pkg::MVM_DEB_COUNT;
            count_d = count_next[CNT_W-1:0];
          end
        end
        mvm_pkg::MVM_DEB_FIRED: begin
          state_d = mvm_pkg::MVM_DEB_FIRED;
        end
        default: begin
          state_d = mvm_pkg::MVM_DEB_IDLE;
          count_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_q <= mvm_pkg::MVM_DEB_IDLE;
      count_q <= '0;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
    end
  end

  assign active_out = state_q == mvm_pkg::MVM_DEB_FIRED;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  a_event_cause: assert property (event_out |-> enable_in && valid_in && over_in && count_q == limit_in) // see R14
    else $error("event without enough over-threshold samples");
  a_event_once: assert property (event_out |=> active_out && !event_out) // see R14
    else $error("event not followed by fired state");

endmodule : mvm_debounce

// ===== hw/mvm_cfg.sv
// Configuration, reference latch and event flag of the vector-magnitude detector

// Functional notes
// R1: Latch on: flag stays set until the event source register is read.
// R2: Latch off: flag follows detection in real time, may clear itself.
// R3: Init mode 0: reference loads from current output when enable is set.
// R4: Init mode 1: reference loads from initial-value inputs when enable is set.
// R5: Update mode 0: reference takes the triggering X, Y, Z on each event.
// R6: Update mode 1: reference stays unchanged on an event.
// R7: Both modes 1 and enabled: initial-value writes reload the reference at once.
// R8: Enable 0 stops detection; enable 1 starts it and loads the reference.
// R9: Host keeps magnetometer output rate at or below 400 Hz.
// R10: Wake enable gates the flag into auto-sleep activity evaluation.
// R11: Interrupt enable 0 keeps both interrupt outputs low.
// R12: Interrupt enable 1 raises an interrupt on a detected event.
// R13: Routing bit 0 sends the interrupt to the second interrupt pin.
// R14: Event when distance exceeds threshold for more than the debounce count.
// R15: Flag reads back as bit 1 of the event source register.
module mvm_cfg #(
  parameter int DATA_W = mvm_pkg::MVM_DATA_W,
  parameter int THS_W = mvm_pkg::MVM_THS_W,
  parameter int CNT_W = mvm_pkg::MVM_CNT_W
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [mvm_pkg::MVM_ADDR_W-1:0] reg_addr_in,
  input wire logic [mvm_pkg::MVM_REG_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [mvm_pkg::MVM_REG_W-1:0] reg_rdata_out,
  input wire logic sample_valid_in,
  input wire logic [DATA_W-1:0] mag_x_in,
  input wire logic [DATA_W-1:0] mag_y_in,
  input wire logic [DATA_W-1:0] mag_z_in,
  input wire logic [DATA_W-1:0] init_x_in,
  input wire logic [DATA_W-1:0] init_y_in,
  input wire logic [DATA_W-1:0] init_z_in,
  input wire logic init_wr_in,
  input wire logic [THS_W-1:0] threshold_in,
  input wire logic [CNT_W-1:0] magnitude_debounce_count_in,
  output logic vecm_flag_out,
  output logic vecm_event_out,
  output logic first_interrupt_pin_out,
  output logic second_interrupt_pin_out,
  output logic wake_source_out
);

  logic [mvm_pkg::MVM_REG_W-1:0] cfg_q;
  logic [mvm_pkg::MVM_REG_W-1:0] cfg_d;
  logic [DATA_W-1:0] ref_x_q;
  logic [DATA_W-1:0] ref_y_q;
  logic [DATA_W-1:0] ref_z_q;
  logic [DATA_W-1:0] ref_x_d;
  logic [DATA_W-1:0] ref_y_d;
  logic [DATA_W-1:0] ref_z_d;
  logic flag_q;
  logic flag_d;
  logic event_q;
  logic [mvm_pkg::MVM_REG_W-1:0] rdata_q;
  logic [mvm_pkg::MVM_REG_W-1:0] rdata_d;

  // Field views of the configuration register
  wire latch_en = cfg_q[mvm_pkg::MVM_CFG_LATCH_BIT];
  wire init_mode = cfg_q[mvm_pkg::MVM_CFG_INITM_BIT];
  wire upd_mode = cfg_q[mvm_pkg::MVM_CFG_UPDM_BIT];
  wire func_en = cfg_q[mvm_pkg::MVM_CFG_EN_BIT];
  wire wake_en = cfg_q[mvm_pkg::MVM_CFG_WAKE_BIT];
  wire int_en = cfg_q[mvm_pkg::MVM_CFG_INT_EN_BIT];
  wire route_first = cfg_q[mvm_pkg::MVM_CFG_ROUTE_BIT];

  // Register decode
  wire cfg_sel = reg_addr_in == mvm_pkg::MVM_CFG_ADDR;
  wire src_sel = reg_addr_in == mvm_pkg::MVM_SRC_ADDR;
  wire cfg_write = reg_wr_in && cfg_sel;
  wire src_read = reg_rd_in && src_sel;
  wire en_rise = cfg_write && reg_wdata_in[mvm_pkg::MVM_CFG_EN_BIT] && !func_en;
  // Init mode of the enabling write picks the source, not the old setting
  wire wr_init_mode = reg_wdata_in[mvm_pkg::MVM_CFG_INITM_BIT];

  // Detector datapath
  wire dist_valid;
  wire dist_over;
  wire [DATA_W-1:0] samp_x;
  wire [DATA_W-1:0] samp_y;
  wire [DATA_W-1:0] samp_z;
  wire deb_event;
  wire deb_active;

  mvm_dist #(
    .DATA_W(DATA_W),
    .THS_W(THS_W)
  ) u_dist (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .sample_valid_in(sample_valid_in),
    .mag_x_in(mag_x_in),
    .mag_y_in(mag_y_in),
    .mag_z_in(mag_z_in),
    .ref_x_in(ref_x_q),
    .ref_y_in(ref_y_q),
    .ref_z_in(ref_z_q),
    .threshold_in(threshold_in),
    .valid_out(dist_valid),
    .over_out(dist_over),
    .samp_x_out(samp_x),
    .samp_y_out(samp_y),
    .samp_z_out(samp_z)
  );

  mvm_debounce #(
    .CNT_W(CNT_W)
  ) u_debounce (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .enable_in(func_en), // see R8
    .valid_in(dist_valid),
    .over_in(dist_over),
    .limit_in(magnitude_debounce_count_in),
    .event_out(deb_event),
    .active_out(deb_active)
  );

  // Reference load sources
  wire load_live = en_rise && !wr_init_mode; // see R3
  wire load_init_start = en_rise && wr_init_mode; // see R4
  wire load_event = func_en && deb_event && !upd_mode; // see R5, R6
  wire load_manual = func_en && init_mode && upd_mode && init_wr_in; // see R7
  wire load_init = load_init_start || load_manual;

  always_comb begin
    ref_x_d = ref_x_q;
    ref_y_d = ref_y_q;
    ref_z_d = ref_z_q;
    if (load_live) begin
      ref_x_d = mag_x_in;
      ref_y_d = mag_y_in;
      ref_z_d = mag_z_in;
    end else if (load_init) begin
      ref_x_d = init_x_in;
      ref_y_d = init_y_in;
      ref_z_d = init_z_in;
    end else if (load_event) begin
      ref_x_d = samp_x;
      ref_y_d = samp_y;
      ref_z_d = samp_z;
    end
  end

  // Flag: latched with read clear (set wins), or real-time
  always_comb begin
    if (latch_en) begin
      flag_d = deb_event || (flag_q && !src_read); // see R1
    end else begin
      flag_d = deb_active; // see R2
    end
  end

  assign cfg_d = cfg_write ? reg_wdata_in : cfg_q;

  // Read data
  always_comb begin
    rdata_d = mvm_pkg::MVM_RDATA_IDLE;
    if (reg_rd_in && cfg_sel) begin
      rdata_d = cfg_q;
    end else if (src_read) begin
      rdata_d[mvm_pkg::MVM_SRC_VECM_BIT] = flag_q; // see R15
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cfg_q <= mvm_pkg::MVM_CFG_RESET;
      ref_x_q <= '0;
      ref_y_q <= '0;
      ref_z_q <= '0;
      flag_q <= 1'b0;
      event_q <= 1'b0;
      rdata_q <= mvm_pkg::MVM_RDATA_IDLE;
    end else begin
      cfg_q <= cfg_d;
      ref_x_q <= ref_x_d;
      ref_y_q <= ref_y_d;
      ref_z_q <= ref_z_d;
      flag_q <= flag_d;
      event_q <= deb_event;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign vecm_flag_out = flag_q;
  assign vecm_event_out = event_q;
  assign wake_source_out = flag_q && wake_en; // see R10
  assign second_interrupt_pin_out = flag_q && int_en && !route_first; // see R11, R12, R13
  assign first_interrupt_pin_out = flag_q && int_en && route_first; // see R11, R12

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  a_latch_hold: assert property (latch_en && flag_q && !src_read |=> flag_q) // see R1
    else $error("latched flag dropped without a read");
  a_latch_read_clear: assert property (latch_en && flag_q && src_read && !deb_event |=> !flag_q) // see R1
    else $error("latched flag not cleared by source read");
  a_realtime_flag: assert property (!latch_en |=> flag_q == $past(deb_active)) // see R2
    else $error("real-time flag does not follow detection");
  a_ref_live_load: assert property (en_rise && !wr_init_mode // see R3
    |=> ref_x_q == $past(mag_x_in) && ref_z_q == $past(mag_z_in))
    else $error("reference not loaded from live output");
  a_ref_init_load: assert property (en_rise && wr_init_mode |=> ref_y_q == $past(init_y_in) && func_en) // see R4
    else $error("reference not loaded from initial values");
  a_ref_event_upd: assert property (func_en && deb_event && !upd_mode && !cfg_write |=> ref_x_q == $past(samp_x)) // see R5
    else $error("reference not refreshed on event");
  a_ref_event_hold: assert property (func_en && deb_event && upd_mode && !cfg_write && !init_wr_in // see R6
    |=> $stable(ref_x_q))
    else $error("reference changed on event in hold mode");
  a_ref_manual: assert property (func_en && init_mode && upd_mode && init_wr_in && !cfg_write // see R7
    |=> ref_z_q == $past(init_z_in))
    else $error("manual reference write ignored");
  a_disabled_quiet: assert property (!func_en |-> !deb_event) // see R8
    else $error("event while function disabled");
  a_wake_gate: assert property (!wake_en |-> !wake_source_out) // see R10
    else $error("wake source without wake enable");
  a_int_off: assert property (!int_en |-> !first_interrupt_pin_out && !second_interrupt_pin_out) // see R11
    else $error("interrupt with interrupt disabled");
  a_int_route: assert property (deb_event && int_en && !route_first ##1 latch_en |-> second_interrupt_pin_out) // see R12, R13
    else $error("event interrupt missing on second pin");
  a_src_readback: assert property (src_read |=> reg_rdata_out[mvm_pkg::MVM_SRC_VECM_BIT] == $past(flag_q)) // see R15
    else $error("source register does not show the flag");
  a_latch_set: assert property (latch_en && deb_event |=> flag_q) // see R1
    else $error("latched flag not set by event");
  a_int_first: assert property (flag_q && int_en && route_first |-> first_interrupt_pin_out) // see R12
    else $error("event interrupt missing on first pin");
  a_int_second: assert property (flag_q && int_en && !route_first |-> !first_interrupt_pin_out) // see R13
    else $error("interrupt on first pin with routing to second");
  a_wake_follow: assert property (wake_en && flag_q |-> wake_source_out) // see R10
    else $error("flag missing from wake source");
  a_event_pulse: assert property (deb_event |=> vecm_event_out) // see R14
    else $error("event pulse not one cycle after detection");
  a_cfg_write: assert property (cfg_write |=> cfg_q == $past(reg_wdata_in)) // see R8
    else $error("configuration write not taken");
  a_ref_quiet: assert property (!load_live && !load_init && !load_event // see R6
    |=> $stable(ref_x_q) && $stable(ref_y_q) && $stable(ref_z_q))
    else $error("reference changed without a load");

  c_latch_read: cover property (latch_en && flag_q ##1 src_read ##1 !flag_q);
  c_realtime_clear: cover property (!latch_en && flag_q ##1 !flag_q);
  c_event_update: cover property (func_en && !upd_mode && deb_event);
  c_manual_reload: cover property (func_en && init_mode && upd_mode && init_wr_in);
  c_int_first: cover property (first_interrupt_pin_out);

endmodule : mvm_cfg

// ===== dv/mvm_host_model.sv
// Host model driving the register bus and the initial-value registers
module mvm_host_model (
  input wire logic clk_in,
  input wire logic [mvm_pkg::MVM_REG_W-1:0] reg_rdata_in,
  output logic [mvm_pkg::MVM_ADDR_W-1:0] reg_addr_out,
  output logic [mvm_pkg::MVM_REG_W-1:0] reg_wdata_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [mvm_pkg::MVM_DATA_W-1:0] init_x_out,
  output logic [mvm_pkg::MVM_DATA_W-1:0] init_y_out,
  output logic [mvm_pkg::MVM_DATA_W-1:0] init_z_out,
  output logic init_wr_out
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    init_x_out = 16'h0000;
    init_y_out = 16'h0000;
    init_z_out = 16'h0000;
    init_wr_out = 1'b0;
  end

  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_in);
    reg_addr_out <= addr;
    reg_wdata_out <= data;
    reg_wr_out <= 1'b1;
    @(posedge clk_in);
    reg_wr_out <= 1'b0;
    // Stale data is not left on the bus
    reg_wdata_out <= ~data;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk_in);
    reg_addr_out <= addr;
    reg_rd_out <= 1'b1;
    @(posedge clk_in);
    reg_rd_out <= 1'b0;
    #1;
    data = reg_rdata_in;
  endtask : read_reg

  task automatic load_init(input logic [15:0] v);
    @(posedge clk_in);
    init_x_out <= v;
    init_y_out <= v;
    init_z_out <= -v;
    init_wr_out <= 1'b1;
    @(posedge clk_in);
    init_wr_out <= 1'b0;
  endtask : load_init
endmodule : mvm_host_model

// ===== dv/mvm_cfg_bench.sv
// Self-checking bench for the vector-magnitude configuration block
module mvm_cfg_bench;
  timeunit 1ns;
  timeprecision 1ns;

  // Samples spaced far wider than the compare path needs
  localparam int GAP = 4;
  localparam logic [7:0] CFG = mvm_pkg::MVM_CFG_ADDR;

  typedef struct packed {
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic [7:0] raddr;
    logic [7:0] exp;
  } mvm_row_t;

  mvm_row_t rows [8] = '{'{8'h69, 8'ha5, 8'h69, 8'ha5}, '{8'h69, 8'h5a, 8'h69, 8'h5a},
    '{8'h69, 8'h01, 8'h69, 8'h01}, '{8'h5e, 8'hff, 8'h69, 8'h01}, '{8'h6a, 8'h33, 8'h69, 8'h01},
    '{8'h00, 8'hc3, 8'h5e, 8'h00}, '{8'h6a, 8'h33, 8'h6a, 8'h00}, '{8'h69, 8'h00, 8'h69, 8'h00}};

  logic clk_in;
  logic sys_rst_in;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic sample_valid;
  logic [15:0] mag_x;
  logic [15:0] mag_y;
  logic [15:0] mag_z;
  logic [15:0] init_x;
  logic [15:0] init_y;
  logic [15:0] init_z;
  logic init_wr;
  logic vecm_flag;
  logic vecm_event;
  logic pin1;
  logic pin2;
  logic wake;
  logic [7:0] rd_data;
  logic [14:0] ths;
  logic [7:0] deb_cnt;
  wire logic [7:0] status;
  int err_total;
  int num_checks;

  // Flag, first pin, second pin, wake source
  assign status = {4'h0, vecm_flag, pin1, pin2, wake};

  mvm_cfg i_dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .sample_valid_in(sample_valid),
    .mag_x_in(mag_x), .mag_y_in(mag_y), .mag_z_in(mag_z), .init_x_in(init_x), .init_y_in(init_y),
    .init_z_in(init_z), .init_wr_in(init_wr), .threshold_in(ths), .magnitude_debounce_count_in(deb_cnt),
    .vecm_flag_out(vecm_flag), .vecm_event_out(vecm_event), .first_interrupt_pin_out(pin1),
    .second_interrupt_pin_out(pin2), .wake_source_out(wake)
  );

  mvm_host_model i_host (
    .clk_in(clk_in), .reg_rdata_in(reg_rdata), .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata),
    .reg_wr_out(reg_wr), .reg_rd_out(reg_rd), .init_x_out(init_x), .init_y_out(init_y),
    .init_z_out(init_z), .init_wr_out(init_wr)
  );

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  task automatic set_mag(input logic [15:0] v);
    mag_x <= v;
    mag_y <= v;
    mag_z <= -v;
  endtask : set_mag

  // One sample pulse, then count event pulses and compare outputs
  task automatic sample(input logic [15:0] v, input logic [7:0] exp_ev, input logic [7:0] exp_st);
    logic [7:0] n;
    n = 8'h00;
    @(posedge clk_in);
    sample_valid <= 1'b1;
    set_mag(v);
    @(posedge clk_in);
    sample_valid <= 1'b0;
    repeat (GAP) begin
      @(posedge clk_in);
      #1;
      if (vecm_event === 1'b1) begin
        n = n + 8'h01;
      end
    end
    check("event count", n, exp_ev);
    check("outputs", status, exp_st);
  endtask : sample

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    complete_run();
  end

  initial begin
    sys_rst_in = 1'b1;
    sample_valid = 1'b0;
    mag_x = 16'h0000;
    mag_y = 16'h0000;
    mag_z = 16'h0000;
    ths = 15'h0064;
    deb_cnt = 8'h01;
    err_total = 0;
    num_checks = 0;
    repeat (6) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    foreach (rows[i]) begin
      i_host.write_reg(rows[i].waddr, rows[i].wdata);
      i_host.read_reg(rows[i].raddr, rd_data);
      check("register read", rd_data, rows[i].exp);
    end
    $display("register access test done");

    set_mag(16'h00c8);
    i_host.write_reg(CFG, 8'hb4);
    sample(16'h00c8, 8'h00, 8'h00);
    sample(16'h00c8, 8'h00, 8'h00);
    sample(16'h0190, 8'h00, 8'h00);
    sample(16'h0190, 8'h01, 8'h0a);
    sample(16'h00c8, 8'h00, 8'h0a);
    i_host.read_reg(mvm_pkg::MVM_SRC_ADDR, rd_data);
    check("event source", rd_data, 8'h02);
    check("outputs", status, 8'h00);
    i_host.read_reg(mvm_pkg::MVM_SRC_ADDR, rd_data);
    check("event source", rd_data, 8'h00);
    $display("latched flag test done");

    i_host.write_reg(CFG, 8'h00);
    set_mag(16'h0000);
    i_host.write_reg(CFG, 8'h3e);
    sample(16'h00c8, 8'h00, 8'h00);
    sample(16'h00c8, 8'h01, 8'h0d);
    sample(16'h00c8, 8'h00, 8'h0d);
    sample(16'h0000, 8'h00, 8'h00);
    $display("real-time flag test done");

    i_host.write_reg(CFG, 8'h00);
    set_mag(16'h0000);
    i_host.write_reg(CFG, 8'h10);
    sample(16'h00c8, 8'h00, 8'h00);
    sample(16'h00c8, 8'h01, 8'h08);
    sample(16'h00c8, 8'h00, 8'h00);
    $display("reference update test done");

    i_host.write_reg(CFG, 8'h00);
    set_mag(16'h0000);
    i_host.load_init(16'h00c8);
    i_host.write_reg(CFG, 8'h74);
    sample(16'h00c8, 8'h00, 8'h00);
    sample(16'h00c8, 8'h00, 8'h00);
    i_host.load_init(16'h0000);
    sample(16'h00c8, 8'h00, 8'h00);
    sample(16'h00c8, 8'h01, 8'h0a);
    $display("initial value test done");

    i_host.write_reg(CFG, 8'h00);
    sample(16'h00c8, 8'h00, 8'h00);
    sample(16'h00c8, 8'h00, 8'h00);
    $display("disable test done");

    deb_cnt <= 8'h00;
    set_mag(16'h0000);
    i_host.write_reg(CFG, 8'h10);
    sample(16'h00c8, 8'h01, 8'h08);
    sample(16'h00c8, 8'h00, 8'h00);
    deb_cnt <= 8'h01;
    i_host.write_reg(CFG, 8'h00);
    $display("zero count test done");

    set_mag(16'h0000);
    i_host.write_reg(CFG, 8'hb4);
    sample(16'h00c8, 8'h00, 8'h00);
    sample(16'h00c8, 8'h01, 8'h0a);
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    check("outputs in reset", status, 8'h00);
    @(posedge clk_in);
    sys_rst_in <= 1'b0;
    i_host.read_reg(CFG, rd_data);
    check("config after reset", rd_data, mvm_pkg::MVM_CFG_RESET);
    $display("mid-run reset test done");
    complete_run();
  end
endmodule : mvm_cfg_bench
